// ===== verilog/timer_pkg.sv
// Purpose: Shared constants for the dual timer/counter block.
// Assumes: One 250 MHz system clock, special function register access.
// Notes:   Offsets are special function register addresses.
package timer_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_RUN_FLAG    = 8'h88;
  localparam logic [7:0] ADDR_MODE        = 8'h89;
  localparam logic [7:0] ADDR_FIRST_LOW   = 8'h8A;
  localparam logic [7:0] ADDR_SECOND_LOW  = 8'h8B;
  localparam logic [7:0] ADDR_FIRST_HIGH  = 8'h8C;
  localparam logic [7:0] ADDR_SECOND_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_DIVIDE      = 8'h8E;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_SECOND_FLAG   = 7;
  localparam int BIT_SECOND_RUN    = 6;
  localparam int BIT_FIRST_FLAG    = 5;
  localparam int BIT_FIRST_RUN     = 4;
  localparam int BIT_SECOND_SOURCE = 6;
  localparam int BIT_SECOND_MODE_HI = 5;
  localparam int BIT_SECOND_MODE_LO = 4;
  localparam int BIT_FIRST_SOURCE  = 2;
  localparam int BIT_FIRST_MODE_HI = 1;
  localparam int BIT_FIRST_MODE_LO = 0;
  localparam int BIT_FIRST_DIV     = 0;
  localparam int BIT_SECOND_DIV    = 1;
  localparam int BIT_THIRD_DIV     = 2;

  // Writable bits of the mode register; bits 7 and 3 read as zero.
  localparam logic [7:0] MODE_WRITE_MASK = 8'h77;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [2:0] DIVIDE_RESET = 3'h0;
  localparam logic       BIT_RESET    = 1'b0;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef logic [1:0] mode_t;
  localparam mode_t MODE_13BIT  = 2'h0;
  localparam mode_t MODE_16BIT  = 2'h1;
  localparam mode_t MODE_RELOAD = 2'h2;
  localparam mode_t MODE_SPLIT  = 2'h3;

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  localparam int              PRESCALE_DIV   = 12;
  localparam int              PRESCALE_W     = 4;
  localparam logic [3:0]      PRESCALE_LAST  = 4'(PRESCALE_DIV - 1);
  localparam logic [3:0]      PRESCALE_RESET = 4'h0;

endpackage : timer_pkg

// ===== verilog/fall_detect.sv
// Purpose: Synchronise a count pin and flag its high-to-low edges.
// Assumes: The pin is asynchronous to mclk.
// Notes:   The edge pulse lags the pin by two mclk edges.
`timescale 1ns/1ps
module fall_detect (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      fall
);

  logic sync1_reg, sync2_reg, prev_reg;
  logic sync1_next, sync2_next, prev_next;

  always_comb begin
    sync1_next = pin;
    sync2_next = sync1_reg;
    prev_next  = sync2_reg;
  end

  // Pin idles high, so reset to one to avoid a false edge.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg  <= prev_next;
    end
  end

  // Only registered samples feed the edge, so one pulse counts once.
  assign fall = prev_reg & ~sync2_reg;

endmodule : fall_detect

// ===== verilog/prescaler.sv
// Purpose: Divide the system clock by twelve as a one-cycle tick.
// Assumes: Free-running from reset release.
// Notes:   Tick is a registered pulse once every twelve cycles.
`timescale 1ns/1ps
module prescaler (
  input  wire logic mclk,
  input  wire logic rst,
  output logic      tick
);

  logic [timer_pkg::PRESCALE_W-1:0] count_reg, count_next;
  logic                             tick_reg, tick_next;

  always_comb begin
    if (count_reg == timer_pkg::PRESCALE_LAST) begin
      count_next = timer_pkg::PRESCALE_RESET;
    end else begin
      count_next = count_reg + 4'h1;
    end
    tick_next = (count_reg == timer_pkg::PRESCALE_LAST);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= timer_pkg::PRESCALE_RESET;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : prescaler

// ===== verilog/dual_timer_counter.sv
// Purpose: Two up-counting timer/counters behind special function regs.
// Assumes: Single mclk domain; count pins are asynchronous.
// Notes:   Read data appears one cycle after the read strobe.
//
// Contract
// - Each unit increments from internal clock or its external pin.
// - Counter operation adds exactly one per detected pin pulse.
// - A unit counts only while its run bit is one; in mode 3 the first unit's high byte follows the second run bit.
// - Timer source per unit is system clock or system clock over 12.
// - First unit has four modes, second unit three.
// - Mode fields: second at bits 5:4, first at 1:0.
// - Mode 0 is 13 bits: high byte plus low five bits.
// - Mode 1 is a full 16-bit counter.
// - Mode 2 counts low byte, reloads it from high byte on overflow.
// - Second unit in mode 3 stops and holds its counts.
// - First unit mode 3 splits into two 8-bit counters.
// - Source-select bit: zero timer, one external pin counter.
// - Overflow sets flag; interrupt vectoring clears it.
// - Divide-select bit zero picks over twelve, one picks undivided.
// - Setting run bit keeps count; counting resumes from held value.
// - A high-to-low pin transition is the counting event.
`timescale 1ns/1ps
module dual_timer_counter (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_we,
  input  wire logic       sfr_re,
  input  wire logic       first_int_ack,
  input  wire logic       second_int_ack,
  input  wire logic       first_count_pin,
  input  wire logic       second_count_pin,
  output logic      [7:0] sfr_rdata,
  output logic            first_overflow_flag,
  output logic            second_overflow_flag
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic sfr_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction : sfr_hit

  // Returns {overflow, value} of one 8-bit increment step.
  function automatic logic [8:0] step8(input logic [7:0] v,
                                       input logic       inc);
    step8 = {1'b0, v} + {8'h00, inc};
  endfunction : step8

  // Returns {overflow, high, low} for modes 0, 1 and 2.
  function automatic logic [16:0] step16(input timer_pkg::mode_t mode,
                                         input logic [7:0] th,
                                         input logic [7:0] tl,
                                         input logic       inc);
    logic [5:0]  low5;
    logic [8:0]  high;
    logic [16:0] full;
    logic [8:0]  low8;
    low5 = {1'b0, tl[4:0]} + {5'h00, inc};
    high = {1'b0, th} + {8'h00, low5[5]};
    full = {1'b0, th, tl} + {16'h0000, inc};
    low8 = step8(tl, inc);
    case (mode)
      timer_pkg::MODE_13BIT: begin
        // Upper three low-byte bits do not take part in the count.
        step16 = {high[8], high[7:0], tl[7:5], low5[4:0]};
      end
      timer_pkg::MODE_16BIT: begin
        step16 = full;
      end
      timer_pkg::MODE_RELOAD: begin
        step16 = {low8[8], th, low8[8] ? th : low8[7:0]};
      end
      default: begin
        step16 = {1'b0, th, tl};
      end
    endcase
  endfunction : step16

  // ****************************************************************
  // State
  // ****************************************************************
  logic       first_run_reg,  first_run_next;
  logic       second_run_reg, second_run_next;
  logic       first_flag_reg, first_flag_next;
  logic       second_flag_reg, second_flag_next;
  logic [7:0] mode_reg,       mode_next;
  logic [2:0] divide_reg,     divide_next;
  logic [7:0] first_count_low_reg,   first_count_low_next;
  logic [7:0] first_count_high_reg,  first_count_high_next;
  logic [7:0] second_count_low_reg,  second_count_low_next;
  logic [7:0] second_count_high_reg, second_count_high_next;
  logic [7:0] rdata_reg,      rdata_next;

  // ****************************************************************
  // Count sources
  // ****************************************************************
  logic [1:0] pins;
  logic [1:0] fall;
  logic       tick12;

  assign pins = {second_count_pin, first_count_pin};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_pin
      fall_detect u_fall (
        .mclk (mclk),
        .rst  (rst),
        .pin  (pins[i]),
        .fall (fall[i])
      );
    end
  endgenerate

  prescaler u_prescaler (
    .mclk (mclk),
    .rst  (rst),
    .tick (tick12)
  );

  timer_pkg::mode_t first_mode, second_mode;
  logic first_source, second_source;
  logic first_timer_tick, second_timer_tick;
  logic first_inc, second_inc, split_high_inc;
  logic wr_ctrl, wr_mode, wr_div, wr_f_low, wr_f_high, wr_s_low, wr_s_high;

  assign first_mode = {mode_reg[timer_pkg::BIT_FIRST_MODE_HI],
                       mode_reg[timer_pkg::BIT_FIRST_MODE_LO]};
  assign second_mode = {mode_reg[timer_pkg::BIT_SECOND_MODE_HI],
                        mode_reg[timer_pkg::BIT_SECOND_MODE_LO]};
  assign first_source  = mode_reg[timer_pkg::BIT_FIRST_SOURCE];
  assign second_source = mode_reg[timer_pkg::BIT_SECOND_SOURCE];

  // Divide bit one selects every cycle, zero the twelve-cycle tick.
  assign first_timer_tick  = divide_reg[timer_pkg::BIT_FIRST_DIV] |
                             tick12;
  assign second_timer_tick = divide_reg[timer_pkg::BIT_SECOND_DIV] |
                             tick12;

  // Source select: zero internal tick, one external pin edge.
  assign first_inc = first_run_reg &
                     (first_source ? fall[0] : first_timer_tick);
  assign second_inc = second_run_reg &
                      (second_source ? fall[1] : second_timer_tick);
  // Split high byte counts only internal ticks under the second run bit.
  assign split_high_inc = (first_mode == timer_pkg::MODE_SPLIT) &
                          second_run_reg & first_timer_tick;

  assign wr_ctrl   = sfr_we & sfr_hit(sfr_addr, timer_pkg::ADDR_RUN_FLAG);
  assign wr_mode   = sfr_we & sfr_hit(sfr_addr, timer_pkg::ADDR_MODE);
  assign wr_div    = sfr_we & sfr_hit(sfr_addr, timer_pkg::ADDR_DIVIDE);
  assign wr_f_low  = sfr_we & sfr_hit(sfr_addr, timer_pkg::ADDR_FIRST_LOW);
  assign wr_f_high = sfr_we & sfr_hit(sfr_addr, timer_pkg::ADDR_FIRST_HIGH);
  assign wr_s_low  = sfr_we & sfr_hit(sfr_addr, timer_pkg::ADDR_SECOND_LOW);
  assign wr_s_high = sfr_we & sfr_hit(sfr_addr, timer_pkg::ADDR_SECOND_HIGH);

  // ****************************************************************
  // Counters and flags
  // ****************************************************************
  logic        first_ovf, second_ovf, split_ovf;
  logic [16:0] first_step, second_step;
  logic [8:0]  split_low, split_high;

  always_comb begin
    first_step  = step16(first_mode, first_count_high_reg,
                         first_count_low_reg, first_inc);
    second_step = step16(second_mode, second_count_high_reg,
                         second_count_low_reg, second_inc);
    split_low   = step8(first_count_low_reg, first_inc);
    split_high  = step8(first_count_high_reg, split_high_inc);
    if (first_mode == timer_pkg::MODE_SPLIT) begin
      first_ovf             = split_low[8];
      split_ovf             = split_high[8];
      first_count_low_next  = split_low[7:0];
      first_count_high_next = split_high[7:0];
    end else begin
      first_ovf             = first_step[16];
      split_ovf             = 1'b0;
      first_count_high_next = first_step[15:8];
      first_count_low_next  = first_step[7:0];
    end
    // Second unit has no split mode: it simply holds there.
    if (second_mode == timer_pkg::MODE_SPLIT) begin
      second_ovf             = 1'b0;
      second_count_high_next = second_count_high_reg;
      second_count_low_next  = second_count_low_reg;
    end else begin
      second_ovf             = second_step[16];
      second_count_high_next = second_step[15:8];
      second_count_low_next  = second_step[7:0];
    end
    // A software write to a count byte takes precedence over counting.
    if (wr_f_low)  first_count_low_next   = sfr_wdata;
    if (wr_f_high) first_count_high_next  = sfr_wdata;
    if (wr_s_low)  second_count_low_next  = sfr_wdata;
    if (wr_s_high) second_count_high_next = sfr_wdata;
  end

  always_comb begin
    // Run bits change only by software; the run edge never clears counts.
    first_run_next  = wr_ctrl ? sfr_wdata[timer_pkg::BIT_FIRST_RUN]
                              : first_run_reg;
    second_run_next = wr_ctrl ? sfr_wdata[timer_pkg::BIT_SECOND_RUN]
                              : second_run_reg;
    // A hardware overflow wins over an acknowledge or a software clear.
    first_flag_next = first_ovf |
      (wr_ctrl ? sfr_wdata[timer_pkg::BIT_FIRST_FLAG]
               : first_flag_reg & ~first_int_ack);
    second_flag_next = second_ovf | split_ovf |
      (wr_ctrl ? sfr_wdata[timer_pkg::BIT_SECOND_FLAG]
               : second_flag_reg & ~second_int_ack);
    mode_next   = wr_mode ? (sfr_wdata & timer_pkg::MODE_WRITE_MASK)
                          : mode_reg;
    divide_next = wr_div ? sfr_wdata[2:0] : divide_reg;
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_re) begin
      case (sfr_addr)
        timer_pkg::ADDR_RUN_FLAG: begin
          rdata_next = {second_flag_reg, second_run_reg,
                        first_flag_reg, first_run_reg, 4'h0};
        end
        timer_pkg::ADDR_MODE:        rdata_next = mode_reg;
        timer_pkg::ADDR_FIRST_LOW:   rdata_next = first_count_low_reg;
        timer_pkg::ADDR_SECOND_LOW:  rdata_next = second_count_low_reg;
        timer_pkg::ADDR_FIRST_HIGH:  rdata_next = first_count_high_reg;
        timer_pkg::ADDR_SECOND_HIGH: rdata_next = second_count_high_reg;
        timer_pkg::ADDR_DIVIDE:      rdata_next = {5'h00, divide_reg};
        default:                     rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      first_run_reg         <= timer_pkg::BIT_RESET;
      second_run_reg        <= timer_pkg::BIT_RESET;
      first_flag_reg        <= timer_pkg::BIT_RESET;
      second_flag_reg       <= timer_pkg::BIT_RESET;
      mode_reg              <= timer_pkg::MODE_RESET;
      divide_reg            <= timer_pkg::DIVIDE_RESET;
      first_count_low_reg   <= timer_pkg::COUNT_RESET;
      first_count_high_reg  <= timer_pkg::COUNT_RESET;
      second_count_low_reg  <= timer_pkg::COUNT_RESET;
      second_count_high_reg <= timer_pkg::COUNT_RESET;
      rdata_reg             <= timer_pkg::COUNT_RESET;
    end else begin
      first_run_reg         <= first_run_next;
      second_run_reg        <= second_run_next;
      first_flag_reg        <= first_flag_next;
      second_flag_reg       <= second_flag_next;
      mode_reg              <= mode_next;
      divide_reg            <= divide_next;
      first_count_low_reg   <= first_count_low_next;
      first_count_high_reg  <= first_count_high_next;
      second_count_low_reg  <= second_count_low_next;
      second_count_high_reg <= second_count_high_next;
      rdata_reg             <= rdata_next;
    end
  end

  assign sfr_rdata            = rdata_reg;
  assign first_overflow_flag  = first_flag_reg;
  assign second_overflow_flag = second_flag_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic first_quiet, second_quiet;
  assign first_quiet  = !wr_f_low && !wr_f_high && !wr_mode && !wr_ctrl;
  assign second_quiet = !wr_s_low && !wr_s_high && !wr_mode && !wr_ctrl;

  stopped_holds_a : assert property (
    !first_run_reg && first_mode != timer_pkg::MODE_SPLIT && first_quiet
    |=> $stable(first_count_low_reg) && $stable(first_count_high_reg))
    else $error("first unit counted while stopped");

  full_count_a : assert property (
    first_run_reg && first_mode == timer_pkg::MODE_16BIT && !first_source
    && divide_reg[timer_pkg::BIT_FIRST_DIV] && first_quiet
    |=> {first_count_high_reg, first_count_low_reg} ==
        16'($past({first_count_high_reg, first_count_low_reg}) + 16'h0001))
    else $error("16-bit count did not step by one");

  reload_low_a : assert property (
    first_inc && first_mode == timer_pkg::MODE_RELOAD &&
    first_count_low_reg == 8'hFF && first_quiet
    |=> first_count_low_reg == $past(first_count_high_reg) &&
        $stable(first_count_high_reg) && first_flag_reg)
    else $error("reload on overflow failed");

  wrap13_a : assert property (
    first_inc && first_mode == timer_pkg::MODE_13BIT &&
    first_count_high_reg == 8'hFF && first_count_low_reg[4:0] == 5'h1F &&
    first_quiet
    |=> first_count_high_reg == 8'h00 &&
        first_count_low_reg[4:0] == 5'h00 && first_flag_reg)
    else $error("13-bit wrap failed");

  second_split_a : assert property (
    second_mode == timer_pkg::MODE_SPLIT && second_quiet
    [*2] |-> $stable(second_count_low_reg) &&
             $stable(second_count_high_reg))
    else $error("second unit moved in mode 3");

  pin_edge_a : assert property (
    first_run_reg && first_source && first_quiet &&
    first_mode == timer_pkg::MODE_16BIT && !fall[0]
    |=> $stable({first_count_high_reg, first_count_low_reg}))
    else $error("counter moved without a pin edge");

  tick_spacing_a : assert property (
    tick12 |=> !tick12 [*8])
    else $error("divided tick too frequent");

  flag_set_wins_a : assert property (
    first_ovf && first_int_ack |=> first_flag_reg)
    else $error("overflow lost against acknowledge");

  ack_clears_a : assert property (
    second_int_ack && !second_ovf && !split_ovf && !wr_ctrl
    |=> !second_flag_reg)
    else $error("acknowledge did not clear flag");

  split_high_a : assert property (
    first_mode == timer_pkg::MODE_SPLIT && !second_run_reg && first_quiet
    |=> $stable(first_count_high_reg))
    else $error("split high byte ran without second run bit");

  reload_c : cover property (first_mode == timer_pkg::MODE_RELOAD &&
                             first_ovf);
  split_c  : cover property (split_ovf);
  pin_c    : cover property (second_source && second_inc);
  wrap_c   : cover property (first_mode == timer_pkg::MODE_13BIT &&
                             first_ovf);

endmodule : dual_timer_counter

// ===== verif/count_source.sv
// Purpose: Far-side model that drives one external count input pin.
// Assumes: The pin idles high between pulses.
// Notes:   Low levels last three mclk cycles and highs four, above the two-cycle minimum.
`timescale 1ns/1ps
module count_source (
  input  wire logic mclk,
  output logic      pin
);
  // ****************************************************************
  // Pulse generation
  // ****************************************************************
  initial pin = 1'b1;

  // The pin only moves just after a rising edge, so a slow synchroniser
  // can never see a level shorter than it needs.
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      pin <= 1'b0;
      repeat (3) @(posedge mclk);
      pin <= 1'b1;
      repeat (3) @(posedge mclk);
    end
  endtask : pulses
endmodule : count_source

// ===== verif/tb.sv
// Purpose: Self-checking bench for the dual timer/counter block.
// Assumes: Registers are reached by one-cycle write and read strobes.
// Notes:   Pin pulses come from two count_source models.
`timescale 1ns/1ps
module tb;
  logic       mclk = 1'b0;
  logic       rst, sfr_we, sfr_re, first_int_ack, second_int_ack;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic       first_overflow_flag, second_overflow_flag;
  logic       first_count_pin, second_count_pin;
  int         n_fail = 0;
  int         n_compared = 0;

  dual_timer_counter dut (
    .mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we), .sfr_re(sfr_re), .first_int_ack(first_int_ack),
    .second_int_ack(second_int_ack), .first_count_pin(first_count_pin),
    .second_count_pin(second_count_pin), .sfr_rdata(sfr_rdata),
    .first_overflow_flag(first_overflow_flag),
    .second_overflow_flag(second_overflow_flag));
  count_source src1 (.mclk(mclk), .pin(first_count_pin));
  count_source src2 (.mclk(mclk), .pin(second_count_pin));

  always #2 mclk = ~mclk;

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_we    <= 1'b1;
    @(posedge mclk);
    sfr_we    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_re   <= 1'b1;
    @(posedge mclk);
    sfr_re   <= 1'b0;
    @(negedge mclk);
    v = sfr_rdata;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(v, exp);
  endtask : rdc

  // Pulses one acknowledge and looks at both flags once it has landed.
  task automatic ack(input logic second);
    @(posedge mclk);
    first_int_ack  <= ~second;
    second_int_ack <= second;
    @(posedge mclk);
    first_int_ack  <= 1'b0;
    second_int_ack <= 1'b0;
    @(negedge mclk);
    check({6'h00, second_overflow_flag, first_overflow_flag}, 8'h00);
  endtask : ack

  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    {sfr_we, sfr_re, first_int_ack, second_int_ack} = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 8'h88; a <= 8'h8F; a++) rdc(8'(a), 8'h00);
    wr(8'h89, 8'hFF);
    rdc(8'h89, 8'h77);
    wr(8'h8E, 8'hFF);
    rdc(8'h8E, 8'h07);
    wr(8'h89, 8'h01);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hF0);
    wr(8'h88, 8'h10);
    for (int i = 0; i < 40 && first_overflow_flag !== 1'b1; i++)
      @(negedge mclk);
    check({7'h00, first_overflow_flag}, 8'h01);
    ack(1'b0);
    wr(8'h88, 8'h00);
    rdc(8'h8C, 8'h00);
    wr(8'h8A, 8'h10);
    repeat (30) @(posedge mclk);
    rdc(8'h8A, 8'h10);
    wr(8'h8E, 8'h00);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    repeat (120) @(posedge mclk);
    wr(8'h88, 8'h00);
    rd(8'h8A);
    check({7'h00, v >= 8'h09 && v <= 8'h0B}, 8'h01);
    wr(8'h89, 8'h05);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    src1.pulses(5);
    rdc(8'h8A, 8'h05);
    wr(8'h89, 8'h04);
    wr(8'h8A, 8'hFF);
    src1.pulses(1);
    rdc(8'h8C, 8'h01);
    rdc(8'h8A, 8'hE0);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hFF);
    src1.pulses(1);
    rdc(8'h8C, 8'h00);
    check({7'h00, first_overflow_flag}, 8'h01);
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h60);
    wr(8'h8D, 8'hFD);
    wr(8'h8B, 8'hFE);
    wr(8'h88, 8'h40);
    src2.pulses(3);
    rdc(8'h8B, 8'hFE);
    rdc(8'h8D, 8'hFD);
    check({7'h00, second_overflow_flag}, 8'h01);
    ack(1'b1);
    wr(8'h89, 8'h70);
    src2.pulses(2);
    rdc(8'h8B, 8'hFE);
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h03);
    wr(8'h8E, 8'h01);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'h33);
    wr(8'h88, 8'h40);
    for (int i = 0; i < 20 && second_overflow_flag !== 1'b1; i++)
      @(negedge mclk);
    check({7'h00, second_overflow_flag}, 8'h01);
    wr(8'h88, 8'h00);
    rdc(8'h8A, 8'h33);
    // High byte FF reloads FF, so the first unit overflows every cycle and
    // the acknowledge below lands on an overflow.
    wr(8'h89, 8'h02);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hFF);
    wr(8'h88, 8'h10);
    @(posedge mclk);
    first_int_ack <= 1'b1;
    @(posedge mclk);
    first_int_ack <= 1'b0;
    @(negedge mclk);
    check({7'h00, first_overflow_flag}, 8'h01);
    rdc(8'h8A, 8'hFF);
    complete_run();
  end

  // Whole sequence needs well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
endmodule : tb
